/* File: core/tile_ps_regs.svh */
// Offsets, field positions, reset values and codes of the tile status and debug bank
`ifndef TILE_PS_REGS_SVH
`define TILE_PS_REGS_SVH

// Identifier layout
`define PS_ID_TYPE           8'h0c
`define PS_ID_NUM_LSB        8

// Register numbers
`define PS_NUM_BOOT_STATUS   8'h03
`define PS_NUM_SECURITY      8'h05
`define PS_NUM_RO_CONTROL    8'h06
`define PS_NUM_RO_TILE_CELL  8'h07
`define PS_NUM_RO_TILE_WIRE  8'h08
`define PS_NUM_RO_PERI_CELL  8'h09
`define PS_NUM_RO_PERI_WIRE  8'h0a
`define PS_NUM_DBG_STATUS    8'h10
`define PS_NUM_DBG_PC        8'h11
`define PS_NUM_DBG_SP        8'h12
`define PS_NUM_DBG_RD_CORE   8'h13
`define PS_NUM_DBG_RD_REG    8'h14
`define PS_NUM_DBG_CAUSE     8'h15
`define PS_NUM_DBG_INFO      8'h16
`define PS_NUM_DBG_STOP      8'h18
`define PS_NUM_SCRATCH_BASE  5'h04

// Field positions
`define BOOT_TILE_LSB        16
`define BOOT_OTP_BIT         8
`define RO_CTRL_TILE_BIT     1
`define RO_CTRL_PERI_BIT     0
`define CAUSE_IDX_LSB        16
`define CAUSE_CORE_LSB       8

// Cause codes and reset values
`define CAUSE_HOST           3'h1
`define CAUSE_DEBUG_CALL     3'h2
`define CAUSE_IBP            3'h3
`define CAUSE_DWP            3'h4
`define CAUSE_RWP            3'h5
`define RO_CTRL_RESET        2'h0
`define CAUSE_RESET          3'h0

`endif

/* File: core/tile_ps_pkg.sv */
// Types shared by the tile status and debug bank and its users
package tile_ps_pkg;

	// Processor status request from the core
	typedef struct packed {
		logic        rd;     // Read strobe
		logic        wr;     // Write strobe
		logic [15:0] id;     // Resource identifier
		logic [31:0] wdata;  // Write word
	} ps_req_s;

	// Answer to a request
	typedef struct packed {
		logic        ack;    // One-cycle completion
		logic        err;    // Bad identifier or unmapped
		logic [31:0] rdata;  // Read word
	} ps_rsp_s;

	// Debug entry event from the pipeline
	typedef struct packed {
		logic        entry;  // One-cycle entry pulse
		logic [2:0]  cause;  // Cause code
		logic [3:0]  hits;   // Breakpoint or watchpoint hits
		logic [7:0]  core;   // Logical core that caused it
		logic [31:0] status; // Saved status word
		logic [31:0] pc;     // Saved program counter
		logic [31:0] sp;     // Saved stack pointer
		logic [31:0] info;   // Address or resource id
	} dbg_evt_s;

	// Scratch access from the configuration path
	typedef struct packed {
		logic        wr;     // Write strobe
		logic [2:0]  idx;    // Word index
		logic [31:0] wdata;  // Write word
	} cfg_scr_s;

endpackage : tile_ps_pkg

/* File: core/tile_status_debug_regs.sv */
// Processor status and debug register bank of one tile
`timescale 1ns/100ps
`include "tile_ps_regs.svh"

module tile_status_debug_regs
	import tile_ps_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        PWR_ON_RST,
	input  wire ps_req_s     PS_REQ,
	output      ps_rsp_s     PS_RSP,
	input  wire logic        DEBUG_MODE,
	input  wire dbg_evt_s    DBG_EVT,
	input  wire logic [7:0]  TILE_NUMBER,
	input  wire logic        OTP_BOOT_EN,
	input  wire logic [31:0] SECURITY_WORD,
	input  wire logic [7:0]  BOOT_MODE_PINS,
	input  wire logic [3:0]  RO_TICK,
	output      logic        RO_TILE_EN,
	output      logic        RO_PERI_EN,
	output      logic [31:0] SAVED_PROGRAM_COUNTER,
	output      logic [31:0] SAVED_STACK_POINTER,
	output      logic [7:0]  DEBUG_READ_CORE,
	output      logic [4:0]  DEBUG_READ_REG,
	output      logic [7:0]  CORE_STOP,
	input  wire cfg_scr_s    CFG_SCR,
	output      logic [31:0] CFG_SCR_RDATA
);

	// Status port behaviour:
	// A request is taken on the edge at which its strobe is high.
	// Ack, err and read data leave the state register one cycle later.
	// Read data holds until the next read; a write leaves it alone.
	// A read and a write in one cycle return the old word, then write.
	// Requests may follow each other on every cycle.
	// A wrong type byte or an unmapped number answers err; a read of one gets zero data.
	// Read-only numbers take a write without error and drop the data.
	// Debug-side words only take core writes while the core is in debug mode.
	// Reads are never gated, so a debugger can always look.
	//
	// Reset behaviour:
	// Both resets are synchronous and clear the whole bank to zero.
	// The oscillator counters are the exception: only power-on clears them.
	// Without a power-on reset they start unknown in simulation.
	// Sync stages are cleared too, so boot pins read zero for two cycles.
	//
	// Oscillator counters:
	// Each oscillator output is synchronised before its edges are counted,
	// so a count lags its oscillator by about three tile clocks.
	// High and low phases shorter than a tile clock may be lost; the
	// count serves as a random source, not as a frequency meter.
	// A word read while its oscillator runs may still be moving.
	// The counters wrap silently at 16 bits.
	//
	// Priority inside one cycle:
	// Debug entry beats a software write to the captured words.
	// A configuration path scratch write beats a core scratch write.
	// The configuration read port shows the word before that cycle's writes.
	//
	// Stop mask:
	// The registered stop lines drop to zero while in debug mode, so the
	// debugger can run a masked core; they return one cycle after exit.

	// Whole state of the bank
	typedef struct packed {
		logic [7:0]        boot_s1;   // Mode pin sync, first stage
		logic [7:0]        boot_s2;   // Mode pin sync, second stage
		logic [3:0]        ro_s1;     // Oscillator sync, first stage
		logic [3:0]        ro_s2;     // Oscillator sync, second stage
		logic [3:0]        ro_prev;   // Previous synced oscillator level
		logic [3:0][15:0]  ro_cnt;    // Oscillator counters
		logic [1:0]        ro_ctrl;   // Oscillator enables
		logic [31:0]       sv_status; // Saved status copy
		logic [31:0]       sv_pc;     // Saved program counter copy
		logic [31:0]       sv_sp;     // Saved stack pointer copy
		logic [7:0]        rd_core;   // Register read core operand
		logic [4:0]        rd_reg;    // Register read number operand
		logic [1:0]        bp_idx;    // Trigger index
		logic [7:0]        int_core;  // Causing core
		logic [2:0]        cause;     // Cause code
		logic [31:0]       int_info;  // Interrupt data
		logic [7:0]        stop_mask; // Per-core stop mask
		logic [7:0][31:0]  scratch;   // Shared scratch words
		logic [7:0]        core_stop; // Registered stop output
		logic [31:0]       cfg_rdata; // Configuration path read word
		ps_rsp_s           rsp;       // Registered answer
	} state_s;

	state_s      st_q;     // Current state
	state_s      st_d;     // Next state
	logic [3:0]  ro_edge;  // Counted oscillator rising edge
	logic [3:0]  ro_run;   // Oscillator enabled
	logic [7:0]  ps_num;   // Decoded register number
	logic        ps_ok;    // Identifier carries the status type
	logic [32:0] rd_word;  // Hit flag and read word

	// Tile pair follows bit 1, peripheral pair bit 0
	assign ro_run = {st_q.ro_ctrl[`RO_CTRL_PERI_BIT], st_q.ro_ctrl[`RO_CTRL_PERI_BIT],
		st_q.ro_ctrl[`RO_CTRL_TILE_BIT], st_q.ro_ctrl[`RO_CTRL_TILE_BIT]};

	// Edge detect per oscillator, only on the second sync stage
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_ro
			assign ro_edge[g] = ro_run[g] & st_q.ro_s2[g] & ~st_q.ro_prev[g];
		end
	endgenerate

	// Identifier decode; low byte is the status resource type
	assign ps_ok  = (PS_REQ.id[7:0] == `PS_ID_TYPE);
	assign ps_num = PS_REQ.id[15:`PS_ID_NUM_LSB];

	// Lowest set trigger wins
	function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (hits[i])
			begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction : lowest_hit

	// Read multiplexer; reserved bits come back as zero
	function automatic logic [32:0] read_word(input logic [7:0] num, input state_s s);
		logic [32:0] w;
		w = {1'b1, 32'h0000_0000};
		case (num)
			`PS_NUM_BOOT_STATUS :
			begin
				w[`BOOT_TILE_LSB +: 8] = TILE_NUMBER;
				w[`BOOT_OTP_BIT]  = OTP_BOOT_EN;
				w[7:0]            = s.boot_s2;
			end
			`PS_NUM_SECURITY :
			begin
				w[31:0] = SECURITY_WORD;
			end
			`PS_NUM_RO_CONTROL :
			begin
				w[1:0] = s.ro_ctrl;
			end
			// Counters are live; stable only while stopped
			`PS_NUM_RO_TILE_CELL : w[15:0] = s.ro_cnt[0];
			`PS_NUM_RO_TILE_WIRE : w[15:0] = s.ro_cnt[1];
			`PS_NUM_RO_PERI_CELL : w[15:0] = s.ro_cnt[2];
			`PS_NUM_RO_PERI_WIRE : w[15:0] = s.ro_cnt[3];
			`PS_NUM_DBG_STATUS   : w[31:0] = s.sv_status;
			`PS_NUM_DBG_PC       : w[31:0] = s.sv_pc;
			`PS_NUM_DBG_SP       : w[31:0] = s.sv_sp;
			`PS_NUM_DBG_RD_CORE  : w[7:0]  = s.rd_core;
			`PS_NUM_DBG_RD_REG   : w[4:0]  = s.rd_reg;
			`PS_NUM_DBG_CAUSE :
			begin
				w[`CAUSE_IDX_LSB +: 2]  = s.bp_idx;
				w[`CAUSE_CORE_LSB +: 8] = s.int_core;
				w[2:0]   = s.cause;
			end
			`PS_NUM_DBG_INFO     : w[31:0] = s.int_info;
			`PS_NUM_DBG_STOP     : w[7:0]  = s.stop_mask;
			default :
			begin
				// Scratch window or unmapped
				if (num[7:3] == `PS_NUM_SCRATCH_BASE)
				begin
					w[31:0] = s.scratch[num[2:0]];
				end
				else
				begin
					w = 33'h0_0000_0000;
				end
			end
		endcase
		return w;
	endfunction : read_word

	// Read word; a process, so that the live inputs sampled inside the
	// function wake it up as well as the arguments do
	always_comb
	begin
		rd_word = read_word(ps_num, st_q);
	end

	// Next-state logic for the whole bank
	always_comb
	begin
		st_d         = st_q;
		st_d.rsp.ack = 1'b0;
		st_d.rsp.err = 1'b0;

		// Two-stage sync of pins and oscillators
		st_d.boot_s1 = BOOT_MODE_PINS;
		st_d.boot_s2 = st_q.boot_s1;
		st_d.ro_s1   = RO_TICK;
		st_d.ro_s2   = st_q.ro_s1;
		st_d.ro_prev = st_q.ro_s2;

		// Count synced edges; wraps at 16 bits
		// Only enabled oscillators count, see the edge detect above
		for (int i = 0; i < 4; i++)
		begin
			if (ro_edge[i])
			begin
				st_d.ro_cnt[i] = st_q.ro_cnt[i] + 16'h0001;
			end
		end

		// Read: answer next cycle
		if (PS_REQ.rd)
		begin
			st_d.rsp.ack   = 1'b1;
			st_d.rsp.err   = ~(ps_ok & rd_word[32]);
			st_d.rsp.rdata = (ps_ok & rd_word[32]) ? rd_word[31:0] : 32'h0000_0000;
		end

		// Write: debug registers only take data in debug mode
		if (PS_REQ.wr)
		begin
			st_d.rsp.ack = 1'b1;
			st_d.rsp.err = ~(ps_ok & rd_word[32]);
			if (ps_ok)
			begin
				case (ps_num)
					`PS_NUM_RO_CONTROL :
					begin
						// Enables are not gated by debug mode
						st_d.ro_ctrl = PS_REQ.wdata[1:0];
					end
					`PS_NUM_DBG_PC :
					begin
						if (DEBUG_MODE)
						begin
							// Debugger may patch the return address
							st_d.sv_pc = PS_REQ.wdata;
						end
					end
					`PS_NUM_DBG_SP :
					begin
						if (DEBUG_MODE)
						begin
							// Debugger may patch the return stack
							st_d.sv_sp = PS_REQ.wdata;
						end
					end
					`PS_NUM_DBG_RD_CORE :
					begin
						if (DEBUG_MODE)
						begin
							// Upper bits are reserved and dropped
							st_d.rd_core = PS_REQ.wdata[7:0];
						end
					end
					`PS_NUM_DBG_RD_REG :
					begin
						if (DEBUG_MODE)
						begin
							// Upper bits are reserved and dropped
							st_d.rd_reg = PS_REQ.wdata[4:0];
						end
					end
					`PS_NUM_DBG_CAUSE :
					begin
						if (DEBUG_MODE)
						begin
							// Debugger may rewrite the cause word by hand
							st_d.bp_idx   = PS_REQ.wdata[`CAUSE_IDX_LSB +: 2];
							st_d.int_core = PS_REQ.wdata[`CAUSE_CORE_LSB +: 8];
							st_d.cause    = PS_REQ.wdata[2:0];
						end
					end
					`PS_NUM_DBG_INFO :
					begin
						if (DEBUG_MODE)
						begin
							// Whole word is writable
							st_d.int_info = PS_REQ.wdata;
						end
					end
					`PS_NUM_DBG_STOP :
					begin
						if (DEBUG_MODE)
						begin
							// Any pattern is kept; one-hot is up to software
							st_d.stop_mask = PS_REQ.wdata[7:0];
						end
					end
					default :
					begin
						// Scratch words; read-only and unmapped numbers drop the data
						if (DEBUG_MODE && ps_num[7:3] == `PS_NUM_SCRATCH_BASE)
						begin
							st_d.scratch[ps_num[2:0]] = PS_REQ.wdata;
						end
					end
				endcase
			end
		end

		// Configuration path write lands after the core write, so it wins a collision
		if (CFG_SCR.wr)
		begin
			st_d.scratch[CFG_SCR.idx] = CFG_SCR.wdata;
		end
		st_d.cfg_rdata = st_q.scratch[CFG_SCR.idx];

		// Debug entry overrides a software write of the same cycle to the words it captures
		if (DBG_EVT.entry)
		begin
			// Capture the interrupted context
			st_d.sv_status = DBG_EVT.status;
			st_d.sv_pc     = DBG_EVT.pc;
			st_d.sv_sp     = DBG_EVT.sp;
			st_d.cause     = DBG_EVT.cause;
			// Host requests have no causing core
			st_d.int_core  = (DBG_EVT.cause == `CAUSE_HOST) ? 8'h00 : DBG_EVT.core;
			// Index only for hardware triggers
			if (DBG_EVT.cause == `CAUSE_IBP || DBG_EVT.cause == `CAUSE_DWP ||
				DBG_EVT.cause == `CAUSE_RWP)
			begin
				st_d.bp_idx = lowest_hit(DBG_EVT.hits);
			end
			else
			begin
				st_d.bp_idx = 2'h0;
			end
			// Data only meaningful for the two watchpoint kinds
			if (DBG_EVT.cause == `CAUSE_DWP || DBG_EVT.cause == `CAUSE_RWP)
			begin
				st_d.int_info = DBG_EVT.info;
			end
		end

		// Masked cores held outside debug mode; cleared while debugging
		st_d.core_stop = DEBUG_MODE ? 8'h00 : st_q.stop_mask;

		// Reset; counters keep their value except at power-on
		if (RST || PWR_ON_RST)
		begin
			// Clear everything, then restore what must survive
			st_d         = '0;
			st_d.ro_ctrl = `RO_CTRL_RESET;
			st_d.cause   = `CAUSE_RESET;
			st_d.ro_cnt  = PWR_ON_RST ? '0 : st_q.ro_cnt;
		end
	end

	// Single state register
	always_ff @(posedge CLK)
	begin
		st_q <= st_d;
	end

	// Outputs straight from the state register
	assign PS_RSP                = st_q.rsp;
	assign RO_TILE_EN            = st_q.ro_ctrl[`RO_CTRL_TILE_BIT];
	assign RO_PERI_EN            = st_q.ro_ctrl[`RO_CTRL_PERI_BIT];
	assign SAVED_PROGRAM_COUNTER = st_q.sv_pc;
	assign SAVED_STACK_POINTER   = st_q.sv_sp;
	assign DEBUG_READ_CORE       = st_q.rd_core;
	assign DEBUG_READ_REG        = st_q.rd_reg;
	assign CORE_STOP             = st_q.core_stop;
	assign CFG_SCR_RDATA         = st_q.cfg_rdata;

endmodule : tile_status_debug_regs

/* File: tb/tile_status_debug_regs_assertions.sv */
// Port checks for the tile status and debug bank
`timescale 1ns/100ps
module tile_status_debug_regs_chk
	import tile_ps_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        PWR_ON_RST,
	input wire ps_req_s     PS_REQ,
	input wire ps_rsp_s     PS_RSP,
	input wire logic        DEBUG_MODE,
	input wire dbg_evt_s    DBG_EVT,
	input wire logic [7:0]  TILE_NUMBER,
	input wire logic        OTP_BOOT_EN,
	input wire logic [31:0] SECURITY_WORD,
	input wire logic        RO_TILE_EN,
	input wire logic        RO_PERI_EN,
	input wire logic [31:0] SAVED_PROGRAM_COUNTER,
	input wire logic [31:0] SAVED_STACK_POINTER,
	input wire logic [7:0]  DEBUG_READ_CORE,
	input wire logic [4:0]  DEBUG_READ_REG,
	input wire logic [7:0]  CORE_STOP,
	input wire cfg_scr_s    CFG_SCR,
	input wire logic [31:0] CFG_SCR_RDATA
);
	// Either reset aborts every check
	default clocking @(posedge CLK); endclocking
	default disable iff (RST || PWR_ON_RST);
	// Request taken, its number, identifier type well formed
	wire logic       req = PS_REQ.rd || PS_REQ.wr;
	wire logic [7:0] num = PS_REQ.id[15:8];
	wire logic       ok  = PS_REQ.id[7:0] == 8'h0c;
	wire logic       rd  = PS_REQ.rd && ok;
	wire logic       wr  = PS_REQ.wr && ok;
	// Config write, then the same word selected next cycle
	sequence s_cw;
		CFG_SCR.wr ##1 CFG_SCR.idx == $past(CFG_SCR.idx);
	endsequence
	property p_ack; req |=> PS_RSP.ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_bad; req && !ok |=> PS_RSP.err && (PS_RSP.rdata == 32'h0 || !$past(PS_REQ.rd)); endproperty
	a_bad: assert property (p_bad) else $error("bad id accepted");
	property p_boot;
		rd && num == 8'h03 |=> PS_RSP.rdata[31:8] == {8'h0, $past(TILE_NUMBER), 7'h0, $past(OTP_BOOT_EN)};
	endproperty
	a_boot: assert property (p_boot) else $error("boot word");
	property p_sec; rd && num == 8'h05 |=> PS_RSP.rdata == $past(SECURITY_WORD); endproperty
	a_sec: assert property (p_sec) else $error("security copy");
	property p_ctl; wr && num == 8'h06 |=> {RO_TILE_EN, RO_PERI_EN} == $past(PS_REQ.wdata[1:0]); endproperty
	a_ctl: assert property (p_ctl) else $error("osc enables");
	property p_cnt; rd && num >= 8'h07 && num <= 8'h0a |=> PS_RSP.rdata[31:16] == 16'h0; endproperty
	a_cnt: assert property (p_cnt) else $error("counter upper bits");
	property p_save;
		DBG_EVT.entry |=> SAVED_PROGRAM_COUNTER == $past(DBG_EVT.pc) && SAVED_STACK_POINTER == $past(DBG_EVT.sp);
	endproperty
	a_save: assert property (p_save) else $error("entry capture");
	property p_core; wr && DEBUG_MODE && num == 8'h13 |=> DEBUG_READ_CORE == $past(PS_REQ.wdata[7:0]); endproperty
	a_core: assert property (p_core) else $error("core select");
	property p_reg; wr && DEBUG_MODE && num == 8'h14 |=> DEBUG_READ_REG == $past(PS_REQ.wdata[4:0]); endproperty
	a_reg: assert property (p_reg) else $error("register select");
	property p_stop; DEBUG_MODE |=> CORE_STOP == 8'h0; endproperty
	a_stop: assert property (p_stop) else $error("stop in debug mode");
	property p_scr; s_cw |=> CFG_SCR_RDATA == $past(CFG_SCR.wdata, 2); endproperty
	a_scr: assert property (p_scr) else $error("scratch word");
endmodule : tile_status_debug_regs_chk

bind tile_status_debug_regs tile_status_debug_regs_chk i_chk (.CLK, .RST, .PWR_ON_RST, .PS_REQ, .PS_RSP,
	.DEBUG_MODE, .DBG_EVT, .TILE_NUMBER, .OTP_BOOT_EN, .SECURITY_WORD, .RO_TILE_EN, .RO_PERI_EN,
	.SAVED_PROGRAM_COUNTER, .SAVED_STACK_POINTER, .DEBUG_READ_CORE, .DEBUG_READ_REG, .CORE_STOP,
	.CFG_SCR, .CFG_SCR_RDATA);

/* File: tb/tb.sv */
// Directed bench for the tile status and debug bank
`timescale 1ns/100ps
module tb
	import tile_ps_pkg::*;
;
	logic        CLK, RST, PWR_ON_RST, DEBUG_MODE, OTP_BOOT_EN, RO_TILE_EN, RO_PERI_EN;
	logic [7:0]  TILE_NUMBER, BOOT_MODE_PINS, CORE_STOP, DEBUG_READ_CORE;
	logic [31:0] SECURITY_WORD, SAVED_PROGRAM_COUNTER, SAVED_STACK_POINTER, CFG_SCR_RDATA;
	logic [4:0]  DEBUG_READ_REG;
	logic [3:0]  RO_TICK;
	ps_req_s     PS_REQ;
	ps_rsp_s     PS_RSP;
	dbg_evt_s    DBG_EVT;
	cfg_scr_s    CFG_SCR;
	int          failures, checks;
	tile_status_debug_regs i_dut (.CLK, .RST, .PWR_ON_RST, .PS_REQ, .PS_RSP, .DEBUG_MODE, .DBG_EVT,
		.TILE_NUMBER, .OTP_BOOT_EN, .SECURITY_WORD, .BOOT_MODE_PINS, .RO_TICK, .RO_TILE_EN, .RO_PERI_EN,
		.SAVED_PROGRAM_COUNTER, .SAVED_STACK_POINTER, .DEBUG_READ_CORE, .DEBUG_READ_REG, .CORE_STOP,
		.CFG_SCR, .CFG_SCR_RDATA);
	// 250 MHz clock
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Step n edges, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : cyc
	// One status access; answer sampled just after the edge that takes it
	task automatic acc(input logic w, input logic [15:0] id, input logic [31:0] d, exp, input logic e);
		cyc(1);
		PS_REQ = '{!w, w, id, d};
		cyc(1);
		PS_REQ = '0;
		chk(32'(PS_RSP.ack), 32'h1);
		chk(32'(PS_RSP.err), 32'(e));
		if (!w)
			chk(PS_RSP.rdata, exp);
	endtask : acc
	task automatic t_static;
		acc(0, 16'h030c, 0, 32'h005a_01a5, 0);
		OTP_BOOT_EN = 1'b0;
		BOOT_MODE_PINS = 8'h3c;
		acc(1, 16'h030c, 32'hffff_ffff, 0, 0);
		acc(0, 16'h030c, 0, 32'h005a_003c, 0);
		acc(1, 16'h050c, 0, 0, 0);
		acc(0, 16'h050c, 0, 32'hc001_d00d, 0);
		acc(0, 16'h030d, 0, 0, 1);
		acc(0, 16'h170c, 0, 0, 1);
		$display("static done");
	endtask : t_static
	// Only the tile pair is enabled; counts must outlive a system reset
	task automatic t_osc;
		acc(1, 16'h060c, 32'hffff_fffe, 0, 0);
		acc(0, 16'h060c, 0, 32'h2, 0);
		chk({30'h0, RO_TILE_EN, RO_PERI_EN}, 32'h2);
		repeat (5)
		begin
			RO_TICK = 4'hf;
			cyc(4);
			RO_TICK = 4'h0;
			cyc(4);
		end
		acc(1, 16'h060c, 0, 0, 0);
		cyc(4);
		RST = 1'b1;
		cyc(1);
		RST = 1'b0;
		chk({30'h0, RO_TILE_EN, RO_PERI_EN}, 32'h0);
		for (int n = 7; n <= 10; n++)
			acc(0, {n[7:0], 8'h0c}, 0, n < 9 ? 32'h5 : 32'h0, 0);
		// Peripheral pair alone; tile counts must stay put
		acc(1, 16'h060c, 32'h0000_0001, 0, 0);
		chk({30'h0, RO_TILE_EN, RO_PERI_EN}, 32'h1);
		repeat (3)
		begin
			RO_TICK = 4'hf;
			cyc(4);
			RO_TICK = 4'h0;
			cyc(4);
		end
		acc(1, 16'h060c, 0, 0, 0);
		cyc(4);
		for (int n = 7; n <= 10; n++)
			acc(0, {n[7:0], 8'h0c}, 0, n < 9 ? 32'h5 : 32'h3, 0);
		$display("osc done");
	endtask : t_osc
	// Every cause code, two hits so the lower index must win
	task automatic t_dbg;
		for (int c = 1; c <= 5; c++)
		begin
			cyc(1);
			DBG_EVT = '{1'b1, c[2:0], 4'b0110, 8'h07, 32'h51, 32'h1000 + c, 32'h2000 + c, 32'h3000 + c};
			cyc(1);
			DBG_EVT.entry = 1'b0;
			chk(SAVED_PROGRAM_COUNTER, 32'h1000 + c);
			chk(SAVED_STACK_POINTER, 32'h2000 + c);
			acc(0, 16'h150c, 0, {14'h0, c >= 3 ? 2'h1 : 2'h0, c == 1 ? 8'h0 : 8'h07, 5'h0, c[2:0]}, 0);
			if (c >= 4)
				acc(0, 16'h160c, 0, 32'h3000 + c, 0);
		end
		DEBUG_MODE = 1'b0;
		acc(1, 16'h110c, 32'hbad, 0, 0);
		chk(SAVED_PROGRAM_COUNTER, 32'h1005);
		DEBUG_MODE = 1'b1;
		acc(1, 16'h110c, 32'h600d, 0, 0);
		chk(SAVED_PROGRAM_COUNTER, 32'h600d);
		acc(1, 16'h100c, 32'h0, 0, 0);
		acc(0, 16'h100c, 0, 32'h51, 0);
		acc(1, 16'h130c, 32'hffff_ffff, 0, 0);
		acc(0, 16'h130c, 0, 32'hff, 0);
		acc(1, 16'h140c, 32'hffff_ffff, 0, 0);
		acc(0, 16'h140c, 0, 32'h1f, 0);
		chk({19'h0, DEBUG_READ_REG, DEBUG_READ_CORE}, 32'h1fff);
		$display("debug done");
	endtask : t_dbg
	task automatic t_stop;
		acc(1, 16'h180c, 32'h0000_0104, 0, 0);
		acc(0, 16'h180c, 0, 32'h4, 0);
		chk(32'(CORE_STOP), 32'h0);
		DEBUG_MODE = 1'b0;
		cyc(2);
		chk(32'(CORE_STOP), 32'h4);
		DEBUG_MODE = 1'b1;
		$display("stop done");
	endtask : t_stop
	// Same words seen from both paths
	task automatic t_scr;
		for (int i = 0; i < 8; i++)
			acc(1, {8'h20 + i[7:0], 8'h0c}, 32'h5c00 + i, 0, 0);
		// Outside debug mode the core may not touch the shared words
		DEBUG_MODE = 1'b0;
		acc(1, 16'h200c, 32'hdead, 0, 0);
		DEBUG_MODE = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			CFG_SCR.idx = i[2:0];
			cyc(2);
			chk(CFG_SCR_RDATA, 32'h5c00 + i);
		end
		CFG_SCR = '{1'b1, 3'h3, 32'h7777};
		cyc(1);
		CFG_SCR.wr = 1'b0;
		acc(0, 16'h230c, 0, 32'h7777, 0);
		$display("scratch done");
	endtask : t_scr
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial
	begin
		failures = 0;
		checks = 0;
		RST = 1'b1;
		PWR_ON_RST = 1'b1;
		DEBUG_MODE = 1'b1;
		PS_REQ = '0;
		DBG_EVT = '0;
		CFG_SCR = '0;
		RO_TICK = 4'h0;
		TILE_NUMBER = 8'h5a;
		OTP_BOOT_EN = 1'b1;
		BOOT_MODE_PINS = 8'ha5;
		SECURITY_WORD = 32'hc001_d00d;
		cyc(4);
		RST = 1'b0;
		PWR_ON_RST = 1'b0;
		// Boot pins need their sync stages refilled
		cyc(3);
		t_static();
		t_osc();
		t_dbg();
		t_stop();
		t_scr();
		give_verdict();
	end
	// Run needs well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge CLK);
		failures++;
		give_verdict();
	end
endmodule : tb
